// ---- hdl/agf_pkg.sv ----
package agf_pkg;
    // control clock and control-cycle timing
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned CTRL_PERIOD_MS = 1;
    localparam int unsigned MS_CYCLES = CLK_HZ / 1000 * CTRL_PERIOD_MS;
    localparam int unsigned GUARD_DELAY_MS = 2000;
    localparam int unsigned GUARD_TICKS = GUARD_DELAY_MS / CTRL_PERIOD_MS;

    // widths of signals, tunable settings and counters
    localparam int unsigned SIG_W = 16;
    localparam int unsigned ANGLE_W = 8;
    localparam int unsigned PERSIST_W = 15;
    localparam int unsigned THRESH_W = 12;
    localparam int unsigned DIV_W = 16;
    localparam int unsigned DLY_W = 11;

    // firing angle span in degrees
    localparam logic [ANGLE_W-1:0] ANGLE_OFF = 8'h00;
    localparam logic [ANGLE_W-1:0] ANGLE_FULL = 8'hb4;

    // reversal settings: ms and 0.1 % of top speed, limits and defaults
    localparam logic [PERSIST_W-1:0] PERSIST_MAX = 15'h7fff;
    localparam logic [PERSIST_W-1:0] PERSIST_DEF = 15'h2710;
    localparam logic [THRESH_W-1:0] THRESH_MAX = 12'h9c4;
    localparam logic [THRESH_W-1:0] THRESH_DEF = 12'h7d0;

    // commutation guard selection codes
    localparam logic [1:0] GUARD_SEL_DIS = 2'h1;
    localparam logic [1:0] GUARD_SEL_IMM = 2'h2;
    localparam logic [1:0] GUARD_SEL_DLY = 2'h3;
    localparam logic [1:0] GUARD_SEL_DEF = GUARD_SEL_DIS;

    typedef enum logic [1:0] {
        MODE_DISABLED,
        MODE_IMMEDIATE,
        MODE_DELAYED
    } agf_mode_e;

    typedef enum logic [1:0] {
        GUARD_IDLE,
        GUARD_ARMED,
        GUARD_DELAY,
        GUARD_TRIP
    } agf_guard_e;

    // reference and feedback travel together
    typedef struct packed {
        logic signed [SIG_W-1:0] ref_val;
        logic signed [SIG_W-1:0] fb_val;
    } agf_pair_s;
endpackage

// ---- hdl/agf_fire_pwm.sv ----
`timescale 1ns/1ps
module agf_fire_pwm (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic enable_in,
    input wire logic bridge_select_in,
    input wire logic [agf_pkg::ANGLE_W-1:0] angle_in,
    output logic fwd_fire_out,
    output logic rev_fire_out
);
    logic [agf_pkg::ANGLE_W-1:0] phase_r;
    logic fire;

    // free phase ramp over one full conduction span
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            phase_r <= agf_pkg::ANGLE_OFF;
        end else if (!enable_in) begin
            phase_r <= agf_pkg::ANGLE_OFF;
        end else if (phase_r == agf_pkg::ANGLE_FULL - 8'h01) begin
            phase_r <= agf_pkg::ANGLE_OFF;
        end else begin
            phase_r <= phase_r + 8'h01;
        end
    end

    // angle above the span saturates to fully on
    assign fire = enable_in && (angle_in > phase_r); // RULE1

    // open-loop test firing; unregulated, so no guard interlock here
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            fwd_fire_out <= 1'b0;
            rev_fire_out <= 1'b0;
        end else begin
            fwd_fire_out <= fire && !bridge_select_in; // RULE2
            rev_fire_out <= fire && bridge_select_in; // RULE2
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);

    property p_angle_off;
        enable_in && angle_in == agf_pkg::ANGLE_OFF
            |=> !fwd_fire_out && !rev_fire_out;
    endproperty
    a_angle_off: assert property (p_angle_off) // RULE1
        else $error("bridge fired at zero angle");

    property p_angle_full;
        (enable_in && angle_in >= agf_pkg::ANGLE_FULL
            && !bridge_select_in) [*2] |=> fwd_fire_out;
    endproperty
    a_angle_full: assert property (p_angle_full) // RULE1
        else $error("forward bridge not fully on at full angle");

    property p_select_rev;
        bridge_select_in |=> !fwd_fire_out;
    endproperty
    a_select_rev: assert property (p_select_rev) // RULE2
        else $error("forward bridge fired with reverse selected");

    c_rev_fire: cover property (rev_fire_out);
endmodule

// ---- hdl/agf_guard_top.sv ----
// Behaviour
// RULE1: test angle 0 keeps bridge off, 180 fires it fully on.
// RULE2: bridge select off fires forward bridge, on fires reverse bridge.
// RULE3: reversal fault when difference exceeds threshold long enough, polarities opposite; code takes signed difference, so only a positive reference faults.
// RULE4: persistence time 0 to 32767 ms, counted before declaring fault.
// RULE5: difference threshold 0.0 to 250.0 percent, default 200.0 percent.
// RULE6: no reversal detection with an AC tachometer feedback source.
// RULE7: guard select 1 disabled, 2 fault immediately, 3 delay before fault.
// RULE8: guard active while regenerating forces current reference to zero.
// RULE9: guard active while motoring disables the regenerative bridge.
// RULE10: immediate mode trips at once when guard fires during regeneration.
// RULE11: regeneration request means current reference and feedback opposite polarity.
// RULE12: guard while motoring logs alarm, continues motoring until regen request.
// RULE13: delay mode coasts on regen demand, trips after two seconds.
// RULE14: persistence timer clears when condition breaks, only continuous time counts.
// RULE15: inputs sampled and guards evaluated once per control cycle.
`timescale 1ns/1ps
module agf_guard_top #(
    parameter int unsigned TICK_CYCLES = agf_pkg::MS_CYCLES
) (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic test_mode_in,
    input wire logic [agf_pkg::ANGLE_W-1:0] conduction_angle_in,
    input wire logic test_bridge_select_in,
    input wire agf_pkg::agf_pair_s speed_in,
    input wire agf_pkg::agf_pair_s cml_in,
    input wire logic fb_ac_tach_in,
    input wire logic [agf_pkg::PERSIST_W-1:0] reversal_persist_time_in,
    input wire logic [agf_pkg::THRESH_W-1:0] reversal_diff_threshold_in,
    input wire logic [1:0] commutation_guard_select_in,
    input wire logic commutation_risk_in,
    input wire logic fault_clear_in,
    output logic fwd_fire_out,
    output logic rev_fire_out,
    output logic regen_bridge_en_out,
    output logic drive_stop_out,
    output logic signed [agf_pkg::SIG_W-1:0] cml_ref_out,
    output logic feedback_reversal_fault_out,
    output logic commutation_guard_fault_out,
    output logic commutation_guard_alarm_out,
    output logic commutation_guard_event_out
);
    // opposite polarity, zero counts as neither side
    function automatic logic agf_opposite(
        input logic signed [agf_pkg::SIG_W-1:0] a,
        input logic signed [agf_pkg::SIG_W-1:0] b
    );
        return (a != '0) && (b != '0) && (a[agf_pkg::SIG_W-1] !=
            b[agf_pkg::SIG_W-1]);
    endfunction

    // selection decode; unknown codes fall back to disabled
    function automatic agf_pkg::agf_mode_e agf_mode(input logic [1:0] sel);
        case (sel)
            agf_pkg::GUARD_SEL_IMM: return agf_pkg::MODE_IMMEDIATE;
            agf_pkg::GUARD_SEL_DLY: return agf_pkg::MODE_DELAYED;
            default: return agf_pkg::MODE_DISABLED; // RULE7
        endcase
    endfunction

    logic [agf_pkg::DIV_W-1:0] div_r;
    logic tick_r;
    logic [agf_pkg::PERSIST_W-1:0] persist_r;
    logic [agf_pkg::DLY_W-1:0] dly_r;
    agf_pkg::agf_guard_e guard_r;
    agf_pkg::agf_guard_e guard_nxt;
    agf_pkg::agf_mode_e mode;
    logic signed [agf_pkg::SIG_W:0] speed_diff;
    logic rev_cond;
    logic regen_req;
    logic guard_start;

    // control-cycle divider, one tick per millisecond
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            div_r <= '0;
            tick_r <= 1'b0;
        end else if (div_r == agf_pkg::DIV_W'(TICK_CYCLES - 1)) begin
            div_r <= '0;
            tick_r <= 1'b1; // RULE15
        end else begin
            div_r <= div_r + 16'h0001;
            tick_r <= 1'b0;
        end
    end

    // reversal condition, sign-extended so the difference cannot wrap
    assign speed_diff = {speed_in.ref_val[agf_pkg::SIG_W-1], speed_in.ref_val}
        - {speed_in.fb_val[agf_pkg::SIG_W-1], speed_in.fb_val};
    assign rev_cond = !fb_ac_tach_in // RULE6
        && agf_opposite(speed_in.ref_val, speed_in.fb_val) // RULE3
        && (speed_diff > $signed({5'h00, reversal_diff_threshold_in})); // RULE5

    // persistence timer saturates rather than wrapping to a false restart
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            persist_r <= '0;
        end else if (tick_r) begin
            if (!rev_cond) begin
                persist_r <= '0; // RULE14
            end else if (persist_r != agf_pkg::PERSIST_MAX) begin
                persist_r <= persist_r + 15'h0001; // RULE4
            end
        end
    end

    // sticky reversal fault; a new set wins over a clear
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            feedback_reversal_fault_out <= 1'b0;
        end else if (tick_r && rev_cond
            && persist_r >= reversal_persist_time_in) begin
            feedback_reversal_fault_out <= 1'b1; // RULE3
        end else if (fault_clear_in) begin
            feedback_reversal_fault_out <= 1'b0;
        end
    end

    assign mode = agf_mode(commutation_guard_select_in); // RULE7
    assign regen_req = agf_opposite(cml_in.ref_val, cml_in.fb_val); // RULE11

    // guard sequencing, evaluated on the control tick only
    always_comb begin
        guard_nxt = guard_r;
        case (guard_r)
            agf_pkg::GUARD_IDLE: begin
                if (mode != agf_pkg::MODE_DISABLED && commutation_risk_in) begin
                    if (!regen_req) begin
                        guard_nxt = agf_pkg::GUARD_ARMED; // RULE12
                    end else if (mode == agf_pkg::MODE_IMMEDIATE) begin
                        guard_nxt = agf_pkg::GUARD_TRIP; // RULE10
                    end else begin
                        guard_nxt = agf_pkg::GUARD_DELAY; // RULE13
                    end
                end
            end
            agf_pkg::GUARD_ARMED: begin
                if (mode == agf_pkg::MODE_DISABLED || !commutation_risk_in) begin
                    guard_nxt = agf_pkg::GUARD_IDLE;
                end else if (regen_req) begin
                    guard_nxt = (mode == agf_pkg::MODE_IMMEDIATE) ?
                        agf_pkg::GUARD_TRIP : agf_pkg::GUARD_DELAY; // RULE12
                end
            end
            agf_pkg::GUARD_DELAY: begin
                if (!regen_req) begin
                    guard_nxt = agf_pkg::GUARD_IDLE; // RULE13
                end else if (dly_r >= agf_pkg::DLY_W'(agf_pkg::GUARD_TICKS - 1))
                begin
                    guard_nxt = agf_pkg::GUARD_TRIP; // RULE13
                end
            end
            agf_pkg::GUARD_TRIP: begin
                if (fault_clear_in) begin
                    guard_nxt = agf_pkg::GUARD_IDLE;
                end
            end
            default: guard_nxt = agf_pkg::GUARD_IDLE;
        endcase
    end

    assign guard_start = tick_r && guard_r == agf_pkg::GUARD_IDLE
        && guard_nxt != agf_pkg::GUARD_IDLE;

    // guard state and two-second demand counter
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            guard_r <= agf_pkg::GUARD_IDLE;
            dly_r <= '0;
        end else if (tick_r) begin
            guard_r <= guard_nxt;
            if (guard_r == agf_pkg::GUARD_DELAY
                && guard_nxt == agf_pkg::GUARD_DELAY) begin
                dly_r <= dly_r + 11'h001; // RULE13
            end else begin
                dly_r <= '0;
            end
        end
    end

    // current reference pass-through, zeroed while regen demand is held off
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            cml_ref_out <= '0;
        end else if (tick_r) begin
            if (guard_nxt == agf_pkg::GUARD_DELAY
                || guard_nxt == agf_pkg::GUARD_TRIP) begin
                cml_ref_out <= '0; // RULE8
            end else begin
                cml_ref_out <= cml_in.ref_val; // RULE15
            end
        end
    end

    // bridge enable, stop and guard flags follow the state
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            regen_bridge_en_out <= 1'b1;
            drive_stop_out <= 1'b0;
            commutation_guard_fault_out <= 1'b0;
            commutation_guard_event_out <= 1'b0;
        end else begin
            regen_bridge_en_out <= guard_r == agf_pkg::GUARD_IDLE; // RULE9
            drive_stop_out <= guard_r == agf_pkg::GUARD_TRIP; // RULE10
            commutation_guard_fault_out <= guard_r == agf_pkg::GUARD_TRIP;
            commutation_guard_event_out <= guard_start; // RULE12
        end
    end

    // sticky alarm; a new event wins over a clear
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            commutation_guard_alarm_out <= 1'b0;
        end else if (guard_start) begin
            commutation_guard_alarm_out <= 1'b1; // RULE12
        end else if (fault_clear_in) begin
            commutation_guard_alarm_out <= 1'b0;
        end
    end

    // test firing and bridge steering run every clock, free of the guard
    agf_fire_pwm agf_fire_pwm_inst (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .enable_in(test_mode_in),
        .bridge_select_in(test_bridge_select_in), // RULE2
        .angle_in(conduction_angle_in), // RULE1
        .fwd_fire_out(fwd_fire_out),
        .rev_fire_out(rev_fire_out)
    );
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);

    property p_rev_fault_cause;
        $rose(feedback_reversal_fault_out) |->
            $past(rev_cond) && $past(tick_r)
            && $past(persist_r) >= $past(reversal_persist_time_in);
    endproperty
    a_rev_fault_cause: assert property (p_rev_fault_cause) // RULE3
        else $error("reversal fault without persistent condition");
    property p_ac_tach;
        tick_r && fb_ac_tach_in |=> persist_r == '0;
    endproperty
    a_ac_tach: assert property (p_ac_tach) // RULE6
        else $error("reversal timer ran with ac tachometer");
    property p_persist_clear;
        tick_r && !rev_cond |=> persist_r == '0;
    endproperty
    a_persist_clear: assert property (p_persist_clear) // RULE14
        else $error("persistence timer not cleared");
    property p_delay_zero_ref;
        tick_r && mode == agf_pkg::MODE_DELAYED && commutation_risk_in
            && regen_req && guard_r == agf_pkg::GUARD_IDLE
            |=> cml_ref_out == '0 ##1 !regen_bridge_en_out;
    endproperty
    a_delay_zero_ref: assert property (p_delay_zero_ref) // RULE8
        else $error("current reference not forced to zero");
    property p_motor_regen_off;
        tick_r && mode != agf_pkg::MODE_DISABLED && commutation_risk_in
            && !regen_req && guard_r == agf_pkg::GUARD_IDLE
            |=> ##1 !regen_bridge_en_out && !drive_stop_out;
    endproperty
    a_motor_regen_off: assert property (p_motor_regen_off) // RULE9
        else $error("regen bridge left on while guarding motoring");
    property p_immediate_trip;
        tick_r && mode == agf_pkg::MODE_IMMEDIATE && commutation_risk_in
            && regen_req && guard_r == agf_pkg::GUARD_IDLE
            |=> ##1 drive_stop_out && commutation_guard_fault_out;
    endproperty
    a_immediate_trip: assert property (p_immediate_trip) // RULE10
        else $error("immediate mode did not stop");
    property p_delay_trip;
        tick_r && guard_r == agf_pkg::GUARD_DELAY && regen_req
            && dly_r == agf_pkg::DLY_W'(agf_pkg::GUARD_TICKS - 1)
            |=> guard_r == agf_pkg::GUARD_TRIP;
    endproperty
    a_delay_trip: assert property (p_delay_trip) // RULE13
        else $error("delay mode did not trip after two seconds");
    property p_event_alarm;
        guard_start |=> commutation_guard_event_out
            && commutation_guard_alarm_out ##1 !commutation_guard_event_out;
    endproperty
    a_event_alarm: assert property (p_event_alarm) // RULE12
        else $error("guard event not logged");
    property p_disabled_idle;
        tick_r && mode == agf_pkg::MODE_DISABLED
            && guard_r == agf_pkg::GUARD_IDLE |=> guard_r == agf_pkg::GUARD_IDLE;
    endproperty
    a_disabled_idle: assert property (p_disabled_idle) // RULE7
        else $error("disabled guard left idle");
    c_rev_fault: cover property ($rose(feedback_reversal_fault_out));
    c_delay_trip: cover property (guard_r == agf_pkg::GUARD_DELAY
        ##1 guard_r == agf_pkg::GUARD_TRIP);
    c_delay_recover: cover property (guard_r == agf_pkg::GUARD_DELAY
        ##1 guard_r == agf_pkg::GUARD_IDLE);
endmodule

// ---- verif/agf_bridge_model.sv ----
`timescale 1ns/1ps
module agf_bridge_model (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic fwd_fire_in,
    input wire logic rev_fire_in,
    input wire logic drive_stop_in,
    input wire logic count_clr_in,
    input wire logic tach_reversed_in,
    input wire logic signed [15:0] motor_speed_in,
    input wire logic signed [15:0] arm_current_in,
    output logic [15:0] fwd_count_out,
    output logic [15:0] rev_count_out,
    output logic signed [15:0] speed_fb_out,
    output logic signed [15:0] current_fb_out
);
    // conduction tally of each bridge, one count per fired clock
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            fwd_count_out <= 16'h0000;
            rev_count_out <= 16'h0000;
        end else if (count_clr_in) begin
            fwd_count_out <= 16'h0000;
            rev_count_out <= 16'h0000;
        end else begin
            fwd_count_out <= fwd_count_out + {15'h0000, fwd_fire_in};
            rev_count_out <= rev_count_out + {15'h0000, rev_fire_in};
        end
    end

    // swapped tach leads flip the sign the regulator sees
    assign speed_fb_out = tach_reversed_in ? -motor_speed_in : motor_speed_in;
    // a stopped drive coasts, so armature current dies away
    assign current_fb_out = drive_stop_in ? 16'sh0000 : arm_current_in;
endmodule

// ---- verif/agf_guard_top_test.sv ----
`timescale 1ns/1ps
module agf_guard_top_test;
    logic clk_sys_in = 1'b0;
    logic reset_in = 1'b1;
    logic test_mode = 1'b0;
    logic sel = 1'b0;
    logic ac_tach = 1'b0;
    logic risk = 1'b0;
    logic clr = 1'b0;
    logic cnt_clr = 1'b0;
    logic tach_rev = 1'b0;
    logic [7:0] angle = 8'h00;
    logic [14:0] persist = 15'h2710;
    logic [11:0] thresh = 12'h7d0;
    logic [1:0] gsel = 2'h1;
    logic signed [15:0] spd = 16'sh0000;
    logic signed [15:0] cref = 16'sh0000;
    logic signed [15:0] cur = 16'sh0000;
    logic signed [15:0] spd_fb, cur_fb, cml_ref;
    logic [15:0] fcnt, rcnt;
    logic fwd, rev, regen_en, stop, rfault, gfault, alarm, ev;
    agf_pkg::agf_pair_s speed_s;
    agf_pkg::agf_pair_s cml_s;
    int failures = 0;
    int checked = 0;
    int events = 0;

    assign speed_s = {spd, spd_fb};
    assign cml_s = {cref, cur_fb};
    always #12.5 clk_sys_in = ~clk_sys_in;
    // the event stands one clock only, so tally it on every edge
    always @(posedge clk_sys_in) if (ev === 1'b1) events++;

    // short tick keeps the 2000-tick guard delay inside the run
    agf_guard_top #(.TICK_CYCLES(4)) agf_guard_top_inst (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .test_mode_in(test_mode),
        .conduction_angle_in(angle),
        .test_bridge_select_in(sel),
        .speed_in(speed_s),
        .cml_in(cml_s),
        .fb_ac_tach_in(ac_tach),
        .reversal_persist_time_in(persist),
        .reversal_diff_threshold_in(thresh),
        .commutation_guard_select_in(gsel),
        .commutation_risk_in(risk),
        .fault_clear_in(clr),
        .fwd_fire_out(fwd),
        .rev_fire_out(rev),
        .regen_bridge_en_out(regen_en),
        .drive_stop_out(stop),
        .cml_ref_out(cml_ref),
        .feedback_reversal_fault_out(rfault),
        .commutation_guard_fault_out(gfault),
        .commutation_guard_alarm_out(alarm),
        .commutation_guard_event_out(ev)
    );

    agf_bridge_model agf_bridge_model_inst (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .fwd_fire_in(fwd),
        .rev_fire_in(rev),
        .drive_stop_in(stop),
        .count_clr_in(cnt_clr),
        .tach_reversed_in(tach_rev),
        .motor_speed_in(spd),
        .arm_current_in(cur),
        .fwd_count_out(fcnt),
        .rev_count_out(rcnt),
        .speed_fb_out(spd_fb),
        .current_fb_out(cur_fb)
    );

    task cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask

    // drop every demand and hold clear across two ticks to leave trip
    task clear_all;
        cyc(1);
        risk <= 1'b0;
        tach_rev <= 1'b0;
        ac_tach <= 1'b0;
        cref <= 16'sh0000;
        cur <= 16'sh0000;
        clr <= 1'b1;
        cyc(8);
        clr <= 1'b0;
        #1;
    endtask

    task gset(input logic [1:0] g, input logic r, input int c, input int f);
        cyc(1);
        gsel <= g;
        risk <= r;
        cref <= 16'(c);
        cur <= 16'(f);
    endtask

    // 360 clocks span two whole phase ramps, so alignment cannot matter
    task fire_run(input logic m, input logic b, input logic [7:0] a);
        cyc(1);
        test_mode <= m;
        sel <= b;
        angle <= a;
        cyc(8);
        cnt_clr <= 1'b1;
        cyc(1);
        cnt_clr <= 1'b0;
        cyc(360);
        #1;
    endtask

    task t_reset;
        cyc(1);
        #1;
        chk(regen_en, 1, "regen bridge after reset");
        chk({stop, gfault, rfault, alarm}, 0, "flags after reset");
        $display("test reset done");
    endtask

    task t_fire;
        logic [7:0] ang[3] = '{8'h00, 8'h5a, 8'hb4};
        for (int b = 0; b < 2; b++) begin
            for (int a = 0; a < 3; a++) begin
                fire_run(1'b1, b[0], ang[a]);
                chk(fcnt, b ? 0 : 2 * ang[a], "forward count");
                chk(rcnt, b ? 2 * ang[a] : 0, "reverse count");
            end
        end
        fire_run(1'b0, 1'b0, 8'hb4);
        chk(fcnt + rcnt, 0, "firing outside test");
        $display("test firing done");
    endtask

    task t_rev;
        int ac_v[4] = '{1, 0, 0, 0};
        int thr_v[4] = '{100, 2000, 100, 2500};
        int spd_v[4] = '{500, 500, 50, 1251};
        int exp_v[4] = '{0, 0, 0, 1};
        cyc(1);
        thresh <= 12'h064;
        persist <= 15'h0003;
        spd <= 16'sh01f4;
        tach_rev <= 1'b1;
        cyc(8);
        tach_rev <= 1'b0;
        cyc(8);
        tach_rev <= 1'b1;
        cyc(12);
        #1;
        chk(rfault, 0, "fault before persistence");
        for (int k = 0; k < 40 && rfault !== 1'b1; k++) cyc(1);
        #1;
        chk(rfault, 1, "fault after persistence");
        clear_all;
        chk(rfault, 0, "fault cleared");
        // zero persistence, so any qualifying tick trips at once
        for (int n = 0; n < 4; n++) begin
            cyc(1);
            ac_tach <= ac_v[n][0];
            thresh <= 12'(thr_v[n]);
            spd <= 16'(spd_v[n]);
            persist <= 15'h0000;
            tach_rev <= 1'b1;
            cyc(40);
            #1;
            chk(rfault, exp_v[n], "reversal table");
            clear_all;
        end
        $display("test reversal done");
    endtask

    task t_guard;
        gset(2'h1, 1'b1, 100, -100);
        cyc(20);
        #1;
        chk(events, 0, "event while disabled");
        chk(regen_en, 1, "regen bridge while disabled");
        chk(cml_ref, 100, "reference while disabled");
        gset(2'h2, 1'b1, 100, -100);
        for (int k = 0; k < 20 && stop !== 1'b1; k++) cyc(1);
        #1;
        chk(stop, 1, "stop on regen guard");
        chk(gfault, 1, "guard fault");
        chk(regen_en, 0, "regen bridge in trip");
        chk(cml_ref, 0, "forced reference");
        chk(events, 1, "single event pulse");
        clear_all;
        chk({stop, gfault, alarm}, 0, "trip cleared");
        gset(2'h2, 1'b1, 100, 100);
        cyc(12);
        #1;
        chk({alarm, regen_en, stop}, 3'h4, "motoring guard");
        chk(cml_ref, 100, "motoring reference");
        gset(2'h2, 1'b1, 100, -100);
        for (int k = 0; k < 20 && stop !== 1'b1; k++) cyc(1);
        #1;
        chk(stop, 1, "stop on regen request");
        clear_all;
        gset(2'h3, 1'b1, 100, -100);
        cyc(12);
        #1;
        chk(cml_ref, 0, "delay forced reference");
        chk({regen_en, stop}, 0, "delay coasting");
        gset(2'h3, 1'b0, 100, 100);
        cyc(12);
        #1;
        chk({regen_en, stop}, 2'h2, "delay recovery");
        gset(2'h3, 1'b1, 100, -100);
        cyc(7000);
        #1;
        chk(stop, 0, "early delay stop");
        for (int k = 0; k < 2000 && stop !== 1'b1; k++) cyc(1);
        #1;
        chk({stop, gfault}, 2'h3, "delay trip");
        $display("test guard done");
    endtask

    task end_of_test;
        $display("comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // reset for three clocks, then the scenarios in turn
    initial begin
        repeat (3) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        t_reset;
        t_fire;
        t_rev;
        t_guard;
        end_of_test;
    end

    // watchdog well past the roughly 11000 clocks the scenarios need
    initial begin
        #800000;
        failures++;
        end_of_test;
    end
endmodule
